// File: common/cmd_pkg.sv
// package: register map, defaults and timing for the command-mode block
package cmd_pkg;
  // register offsets (byte addresses, word aligned)
  localparam logic [7:0] OFS_CTRL      = 8'h00; // write: bit0 quit, bit1 apply, bit2 survey start
  localparam logic [7:0] OFS_STATUS    = 8'h04; // read: mode, apply busy, survey busy
  localparam logic [7:0] OFS_GUARD     = 8'h08;
  localparam logic [7:0] OFS_SYMBOL    = 8'h0c;
  localparam logic [7:0] OFS_IDLE_TO   = 8'h10;
  localparam logic [7:0] OFS_JOIN      = 8'h14;
  localparam logic [7:0] OFS_BUSYFAIL  = 8'h18;
  localparam logic [7:0] OFS_NOREPLY   = 8'h1c;
  localparam logic [7:0] OFS_LEVEL     = 8'h20;
  localparam logic [7:0] OFS_FW_VER    = 8'h24;
  localparam logic [7:0] OFS_HW_VER    = 8'h28;
  localparam logic [7:0] OFS_SURV_EXP  = 8'h2c;
  localparam logic [7:0] OFS_SURV_RES  = 8'h30; // read pops next survey result
  localparam logic [7:0] OFS_VER_LONG  = 8'h34; // read steps through verbose text
  // control bit positions
  localparam int CTRL_QUIT   = 0;
  localparam int CTRL_APPLY  = 1;
  localparam int CTRL_SURVEY = 2;
  // join option bit positions
  localparam int JOIN_ANY_NET  = 0;
  localparam int JOIN_ANY_FREQ = 1;
  localparam int JOIN_KEEP_TRY = 2;
  localparam int JOIN_WAKE_FET = 3;
  // reset values and ranges
  localparam logic [11:0] GUARD_RST    = 12'h3e8;
  localparam logic [11:0] GUARD_MIN    = 12'h002;
  localparam logic [11:0] GUARD_MAX    = 12'hce4;
  localparam logic [7:0]  SYMBOL_RST   = 8'h2b;
  localparam logic [15:0] IDLE_TO_RST  = 16'h0064;
  localparam logic [15:0] IDLE_TO_MIN  = 16'h0002;
  localparam logic [3:0]  JOIN_RST     = 4'h0;
  localparam logic [6:0]  LEVEL_MAX    = 7'h64;
  localparam logic [2:0]  SURV_EXP_MAX = 3'h6;
  localparam logic [15:0] SAT_MAX      = 16'hffff;
  localparam int          NUM_CHAN     = 16;
  // timing: 10 MHz clock
  localparam int CLK_HZ       = 10000000;
  localparam int MS_UNIT_NS   = 1000000;
  localparam int IDLE_UNIT_NS = 100000000;
  localparam int DWELL_UNIT_NS = 15360000; // 15.36 ms base dwell
  localparam int NS_PER_S     = 1000000000;
  localparam int MS_CYC    = MS_UNIT_NS / (NS_PER_S / CLK_HZ);
  localparam int IDLE_CYC  = IDLE_UNIT_NS / (NS_PER_S / CLK_HZ);
  localparam int DWELL_CYC = DWELL_UNIT_NS / (NS_PER_S / CLK_HZ);
  localparam int APPLY_CYC = 16; // reinit pulse length
endpackage

// File: design/cmd_mode_ctl.sv
// command-mode controller: escape detect, timeouts, counters, survey, versions
`timescale 1ns/1ps
`default_nettype none
module cmd_mode_ctl #(
  parameter logic [15:0] FW_VERSION = 16'h1234, // arbitrary value
  parameter logic [15:0] HW_VERSION = 16'h5678, // arbitrary value
  parameter int          MS_CYC     = cmd_pkg::MS_CYC,
  parameter int          IDLE_CYC   = cmd_pkg::IDLE_CYC,
  parameter int          DWELL_CYC  = cmd_pkg::DWELL_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  output logic             data_valid,
  output logic [7:0]       data_char,
  input  wire logic        cmd_valid,
  input  wire logic        busy_withheld,
  input  wire logic        retries_exhausted,
  input  wire logic        good_rx,
  input  wire logic [6:0]  good_rx_level,
  input  wire logic        beacon_net,
  input  wire logic [7:0]  energy_in,
  output logic             cmd_mode,
  output logic             reinit,
  output logic [3:0]       survey_chan,
  output logic             survey_busy,
  output logic             any_network_join,
  output logic             any_frequency_join,
  output logic             keep_trying_join,
  output logic             wake_pin_fetch_pending
);
  typedef enum logic [2:0] {ESC_IDLE, ESC_PRE, ESC_SEQ, ESC_POST, ESC_CMD} cmd_esc_t;

  // ---- settings ----
  logic [11:0] guard_reg, guard_next;
  logic [7:0]  symbol_reg, symbol_next;
  logic [15:0] idle_to_reg, idle_to_next;
  logic [3:0]  join_reg, join_next, join_live_reg, join_live_next;
  logic [2:0]  exp_reg, exp_next;
  logic [6:0]  level_reg, level_next;

  // register writes; range-limited values clamp; join applies on reinit
  always_comb begin
    guard_next   = guard_reg;
    symbol_next  = symbol_reg;
    idle_to_next = idle_to_reg;
    join_next    = join_reg;
    exp_next     = exp_reg;
    level_next   = good_rx ? good_rx_level : level_reg;
    if (level_next > cmd_pkg::LEVEL_MAX) level_next = cmd_pkg::LEVEL_MAX;
    if (wr) begin
      case (addr)
        cmd_pkg::OFS_GUARD: begin
          guard_next = wdata[11:0];
          if (wdata[11:0] < cmd_pkg::GUARD_MIN) guard_next = cmd_pkg::GUARD_MIN;
          if (wdata[11:0] > cmd_pkg::GUARD_MAX) guard_next = cmd_pkg::GUARD_MAX;
        end
        cmd_pkg::OFS_SYMBOL:  symbol_next = wdata[7:0];
        cmd_pkg::OFS_IDLE_TO: begin
          idle_to_next = (wdata[15:0] < cmd_pkg::IDLE_TO_MIN) ? cmd_pkg::IDLE_TO_MIN
                                                              : wdata[15:0];
        end
        cmd_pkg::OFS_JOIN:     join_next = wdata[3:0];
        cmd_pkg::OFS_SURV_EXP: begin
          exp_next = (wdata[2:0] > cmd_pkg::SURV_EXP_MAX) ? cmd_pkg::SURV_EXP_MAX : wdata[2:0];
        end
        default: ;
      endcase
    end
    join_live_next = reinit ? join_reg : join_live_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_reg     <= cmd_pkg::GUARD_RST;
      symbol_reg    <= cmd_pkg::SYMBOL_RST;
      idle_to_reg   <= cmd_pkg::IDLE_TO_RST;
      join_reg      <= cmd_pkg::JOIN_RST;
      join_live_reg <= cmd_pkg::JOIN_RST;
      exp_reg       <= 3'h0;
      level_reg     <= 7'h00;
    end else begin
      guard_reg     <= guard_next;
      symbol_reg    <= symbol_next;
      idle_to_reg   <= idle_to_next;
      join_reg      <= join_next;
      join_live_reg <= join_live_next;
      exp_reg       <= exp_next;
      level_reg     <= level_next;
    end
  end

  // join option outputs from the applied value
  assign any_network_join       = join_live_reg[cmd_pkg::JOIN_ANY_NET];
  assign any_frequency_join     = join_live_reg[cmd_pkg::JOIN_ANY_FREQ];
  assign keep_trying_join       = join_live_reg[cmd_pkg::JOIN_KEEP_TRY] && !beacon_net;
  assign wake_pin_fetch_pending = join_live_reg[cmd_pkg::JOIN_WAKE_FET];

  // ---- escape sequence and command mode ----
  logic ms_tick, idle_tick;
  logic ctrl_wr, quit_req, apply_req, survey_req;
  assign ctrl_wr    = wr && addr == cmd_pkg::OFS_CTRL;
  assign quit_req   = ctrl_wr && wdata[cmd_pkg::CTRL_QUIT];
  assign apply_req  = ctrl_wr && wdata[cmd_pkg::CTRL_APPLY];
  assign survey_req = ctrl_wr && wdata[cmd_pkg::CTRL_SURVEY];

  cmd_tick #(.DIV(MS_CYC)) u_ms_tick (
    .clk     (clk),
    .rst     (rst),
    .restart (rx_valid),
    .tick    (ms_tick)
  );
  cmd_tick #(.DIV(IDLE_CYC)) u_idle_tick (
    .clk     (clk),
    .rst     (rst),
    .restart (cmd_valid),
    .tick    (idle_tick)
  );

  cmd_esc_t    esc_reg, esc_next;
  logic [11:0] quiet_reg, quiet_next;
  logic [15:0] idle_reg, idle_next;
  logic        pass_valid_next;

  // escape detection: guard silence, symbol, guard silence
  always_comb begin
    esc_next        = esc_reg;
    quiet_next      = quiet_reg;
    idle_next       = idle_reg;
    pass_valid_next = 1'b0;
    if (rx_valid) begin
      quiet_next = 12'h000;
    end else if (ms_tick && quiet_reg != 12'hfff) begin
      quiet_next = quiet_reg + 12'h001;
    end
    case (esc_reg)
      ESC_IDLE, ESC_PRE: begin
        if (rx_valid) begin
          pass_valid_next = 1'b1;
          if (esc_reg == ESC_PRE && rx_char == symbol_reg) begin
            esc_next        = ESC_SEQ;
            pass_valid_next = 1'b0;
          end else begin
            esc_next = ESC_IDLE;
          end
        end else if (quiet_reg >= guard_reg) begin
          esc_next = ESC_PRE;
        end
      end
      ESC_SEQ, ESC_POST: begin
        if (rx_valid) begin
          esc_next        = ESC_IDLE;
          pass_valid_next = 1'b1;
        end else if (quiet_reg >= guard_reg) begin
          esc_next  = ESC_CMD;
          idle_next = 16'h0000;
        end
      end
      ESC_CMD: begin
        if (cmd_valid) begin
          idle_next = 16'h0000;
        end else if (idle_tick) begin
          idle_next = idle_reg + 16'h0001;
        end
        if (quit_req) begin
          esc_next = ESC_IDLE;
        end else if (!cmd_valid && idle_reg >= idle_to_reg) begin
          esc_next = ESC_IDLE;
        end
      end
      default: esc_next = ESC_IDLE;
    endcase
  end

  logic [7:0] data_char_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      esc_reg       <= ESC_IDLE;
      quiet_reg     <= 12'h000;
      idle_reg      <= 16'h0000;
      data_valid    <= 1'b0;
      data_char_reg <= 8'h00;
    end else begin
      esc_reg       <= esc_next;
      quiet_reg     <= quiet_next;
      idle_reg      <= idle_next;
      data_valid    <= pass_valid_next;
      data_char_reg <= rx_char;
    end
  end
  assign data_char = data_char_reg;
  assign cmd_mode  = (esc_reg == ESC_CMD);

  // ---- apply: reinit pulse ----
  logic [4:0] apply_reg, apply_next;
  always_comb begin
    apply_next = apply_reg;
    if (apply_req) apply_next = 5'(cmd_pkg::APPLY_CYC);
    else if (apply_reg != 5'h00) apply_next = apply_reg - 5'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) apply_reg <= 5'h00;
    else     apply_reg <= apply_next;
  end
  assign reinit = (apply_reg != 5'h00);

  // ---- diagnostic counters ----
  logic [15:0] busy_cnt, noreply_cnt;
  cmd_satcnt u_busy_cnt (
    .clk      (clk),
    .rst      (rst),
    .event_in (busy_withheld),
    .clear    (wr && addr == cmd_pkg::OFS_BUSYFAIL && wdata[15:0] == 16'h0000),
    .count    (busy_cnt)
  );
  cmd_satcnt u_noreply_cnt (
    .clk      (clk),
    .rst      (rst),
    .event_in (retries_exhausted),
    .clear    (wr && addr == cmd_pkg::OFS_NOREPLY && wdata[15:0] == 16'h0000),
    .count    (noreply_cnt)
  );

  // ---- energy survey: dwell (2^exp)*15.36 ms per channel, peak kept ----
  logic [31:0] dwell_reg, dwell_next;
  logic [3:0]  chan_reg, chan_next, rd_ptr_reg, rd_ptr_next;
  logic        surv_reg, surv_next;
  logic [7:0]  peak_reg, peak_next;
  logic [7:0]  res_mem [cmd_pkg::NUM_CHAN];
  logic        res_we;

  always_comb begin
    dwell_next  = dwell_reg;
    chan_next   = chan_reg;
    surv_next   = surv_reg;
    peak_next   = peak_reg;
    rd_ptr_next = rd_ptr_reg;
    res_we      = 1'b0;
    if (rd && addr == cmd_pkg::OFS_SURV_RES) rd_ptr_next = rd_ptr_reg + 4'h1;
    if (survey_req && !surv_reg) begin
      surv_next   = 1'b1;
      chan_next   = 4'h0;
      rd_ptr_next = 4'h0;
      peak_next   = 8'hff;
      dwell_next  = 32'(DWELL_CYC) << exp_reg;
    end else if (surv_reg) begin
      if (energy_in < peak_next) peak_next = energy_in; // smaller -dBm is stronger
      if (dwell_reg <= 32'h1) begin
        res_we     = 1'b1;
        peak_next  = 8'hff;
        dwell_next = 32'(DWELL_CYC) << exp_reg;
        chan_next  = chan_reg + 4'h1;
        if (chan_reg == 4'(cmd_pkg::NUM_CHAN - 1)) surv_next = 1'b0;
      end else begin
        dwell_next = dwell_reg - 32'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dwell_reg  <= 32'h0;
      chan_reg   <= 4'h0;
      surv_reg   <= 1'b0;
      peak_reg   <= 8'hff;
      rd_ptr_reg <= 4'h0;
    end else begin
      dwell_reg  <= dwell_next;
      chan_reg   <= chan_next;
      surv_reg   <= surv_next;
      peak_reg   <= peak_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end
  always_ff @(posedge clk) begin
    if (res_we) res_mem[chan_reg] <= (energy_in < peak_reg) ? energy_in : peak_reg;
  end
  assign survey_chan = chan_reg;
  assign survey_busy = surv_reg;

  // ---- verbose version text: build, mac, phy, boot words ----
  logic [1:0] ver_idx_reg, ver_idx_next;
  logic [31:0] ver_word;
  always_comb begin
    ver_idx_next = ver_idx_reg;
    if (rd && addr == cmd_pkg::OFS_VER_LONG) ver_idx_next = ver_idx_reg + 2'h1;
    case (ver_idx_reg)
      2'h0:    ver_word = {8'h42, 8'h3a, FW_VERSION};
      2'h1:    ver_word = {8'h4d, 8'h3a, FW_VERSION};
      2'h2:    ver_word = {8'h50, 8'h3a, FW_VERSION};
      default: ver_word = {8'h4c, 8'h3a, HW_VERSION};
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ver_idx_reg <= 2'h0;
    else     ver_idx_reg <= ver_idx_next;
  end

  // ---- read mux, data one cycle after strobe ----
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0;
    if (rd) begin
      case (addr)
        cmd_pkg::OFS_STATUS:   rdata_next = {29'h0, surv_reg, reinit, cmd_mode};
        cmd_pkg::OFS_GUARD:    rdata_next = {20'h0, guard_reg};
        cmd_pkg::OFS_SYMBOL:   rdata_next = {24'h0, symbol_reg};
        cmd_pkg::OFS_IDLE_TO:  rdata_next = {16'h0, idle_to_reg};
        cmd_pkg::OFS_JOIN:     rdata_next = {28'h0, join_reg};
        cmd_pkg::OFS_BUSYFAIL: rdata_next = {16'h0, busy_cnt};
        cmd_pkg::OFS_NOREPLY:  rdata_next = {16'h0, noreply_cnt};
        cmd_pkg::OFS_LEVEL:    rdata_next = {25'h0, level_reg};
        cmd_pkg::OFS_FW_VER:   rdata_next = {16'h0, FW_VERSION};
        cmd_pkg::OFS_HW_VER:   rdata_next = {16'h0, HW_VERSION};
        cmd_pkg::OFS_SURV_EXP: rdata_next = {29'h0, exp_reg};
        cmd_pkg::OFS_SURV_RES: rdata_next = {24'h0, res_mem[rd_ptr_reg]};
        cmd_pkg::OFS_VER_LONG: rdata_next = ver_word;
        default:               rdata_next = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata <= 32'h0;
    else     rdata <= rdata_next;
  end

  // ---- checks ----
  enter_guard_a: assert property (@(posedge clk) disable iff (rst)
    (esc_reg != ESC_CMD && esc_next == ESC_CMD) |-> (quiet_reg >= guard_reg && !rx_valid))
    else $error("entry without guard silence");
  quit_exit_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_mode && quit_req) |=> !cmd_mode)
    else $error("quit did not leave command mode");
  stray_cancel_a: assert property (@(posedge clk) disable iff (rst)
    (rx_valid && (esc_reg == ESC_SEQ || esc_reg == ESC_POST)) |=> (esc_reg == ESC_IDLE && data_valid))
    else $error("stray char did not cancel entry");
  idle_exit_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_mode && !quit_req && !cmd_valid && idle_reg >= idle_to_reg) |=> !cmd_mode)
    else $error("idle timeout missed");
  apply_pulse_a: assert property (@(posedge clk) disable iff (rst)
    apply_req |=> reinit [*8])
    else $error("reinit pulse too short");
  level_range_a: assert property (@(posedge clk) disable iff (rst)
    level_reg <= cmd_pkg::LEVEL_MAX)
    else $error("signal level out of range");
  join_keep_a: assert property (@(posedge clk) disable iff (rst)
    beacon_net |-> !keep_trying_join)
    else $error("retry join in beacon net");
  read_late_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == cmd_pkg::OFS_FW_VER) |=> rdata == {16'h0, FW_VERSION})
    else $error("firmware version read wrong");
endmodule // cmd_mode_ctl
`default_nettype wire

// File: design/cmd_satcnt.sv
// saturating 16-bit event counter with software clear
`timescale 1ns/1ps
`default_nettype none
module cmd_satcnt (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        event_in,
  input  wire logic        clear,
  output logic [15:0]      count
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  // clear with an event in the same cycle loads one; stop at all ones
  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = 16'h0000;
    end
    if (event_in) begin
      if (clear) begin
        cnt_next = 16'h0001;
      end else if (cnt_reg != cmd_pkg::SAT_MAX) begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count = cnt_reg;

  sat_hold_a: assert property (@(posedge clk) disable iff (rst)
    (cnt_reg == cmd_pkg::SAT_MAX && !clear) |=> cnt_reg == cmd_pkg::SAT_MAX)
    else $error("counter left saturation");
  sat_clear_a: assert property (@(posedge clk) disable iff (rst)
    (clear && !event_in) |=> cnt_reg == 16'h0000)
    else $error("counter clear failed");
endmodule // cmd_satcnt
`default_nettype wire

// File: design/cmd_tick.sv
// tick generator: one-cycle pulse every div clocks
`timescale 1ns/1ps
`default_nettype none
module cmd_tick #(
  parameter int DIV = 10000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  // count down, pulse at end, restart clears phase
  always_comb begin
    if (restart || cnt_reg == 32'h0) begin
      cnt_next = 32'(DIV - 1);
    end else begin
      cnt_next = cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = (cnt_reg == 32'h0) && !restart;
endmodule // cmd_tick
`default_nettype wire

// File: test/cmd_host_model.sv
// host model: serial characters and guarded escape sequences
`timescale 1ns/1ps
`default_nettype none
module cmd_host_model (
  input  wire logic clk,
  output logic      rx_valid,
  output logic [7:0] rx_char
);
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end
  // one character for one cycle; idle line shows the inverse
  task automatic send_char(input logic [7:0] c);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
  endtask
  // silence, symbol, silence
  task automatic escape(input int q, input logic [7:0] c);
    repeat (q) @(posedge clk);
    send_char(c);
    repeat (q) @(posedge clk);
  endtask
endmodule // cmd_host_model
`default_nettype wire

// File: test/command_mode_and_diagnostics_test.sv
// testbench: registers, escape entry and exit, counters, join options, survey
`timescale 1ns/1ps
`default_nettype none
module command_mode_and_diagnostics_test;
  localparam logic [15:0] FW = 16'h0a51; // arbitrary value
  localparam logic [15:0] HW = 16'h0b62; // arbitrary value
  localparam int          GQ = 14;       // guard of 2 ms (8 cycles) plus margin
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        good_rx = 1'b0;
  logic        beacon_net = 1'b0;
  logic [1:0]  ev = 2'b00;
  logic [6:0]  good_rx_level = 7'h00;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  energy_in = 8'h50;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [7:0]  rx_char, data_char;
  logic        rx_valid, data_valid, cmd_mode, reinit, survey_busy;
  logic [3:0]  survey_chan, join_o;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  logic [31:0] vt [4];
  // clock
  always #50 clk = ~clk;
  cmd_host_model u_host (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char));
  cmd_mode_ctl #(.FW_VERSION(FW), .HW_VERSION(HW), .MS_CYC(4), .IDLE_CYC(8), .DWELL_CYC(4))
  u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_valid(rx_valid), .rx_char(rx_char), .data_valid(data_valid), .data_char(data_char),
    .cmd_valid(cmd_valid), .busy_withheld(ev[0]), .retries_exhausted(ev[1]),
    .good_rx(good_rx), .good_rx_level(good_rx_level), .beacon_net(beacon_net),
    .energy_in(energy_in), .cmd_mode(cmd_mode), .reinit(reinit), .survey_chan(survey_chan),
    .survey_busy(survey_busy), .any_network_join(join_o[0]), .any_frequency_join(join_o[1]),
    .keep_trying_join(join_o[2]), .wake_pin_fetch_pending(join_o[3])
  );
  // channel energy falls with channel number
  always @(posedge clk) energy_in <= 8'h50 - {4'h0, survey_chan};
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // register write, one idle cycle after it
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask
  // register read, data checked in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), e, rdata);
    @(posedge clk);
  endtask
  // one serial character, whether it came out as data, then q + 1 quiet cycles
  task automatic ser(input logic [7:0] c, input logic pass, input int q);
    u_host.send_char(c);
    #1;
    chk("data_valid", {31'h0, pass}, {31'h0, data_valid});
    if (pass) chk("data_char", {24'h0, c}, {24'h0, data_char});
    repeat (q + 1) @(posedge clk);
  endtask
  // length of a high phase of reinit or survey_busy
  task automatic hold_len(input bit s, input int e);
    int n;
    n = 0;
    while ((s ? survey_busy : reinit) === 1'b1 && n < 400) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    chk(s ? "survey_len" : "reinit_len", e, n);
  endtask
  task automatic mode_is(input logic m);
    #1;
    chk("cmd_mode", {31'h0, m}, {31'h0, cmd_mode});
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    vt = '{{16'h423a, FW}, {16'h4d3a, FW}, {16'h503a, FW}, {16'h4c3a, HW}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, read-only places, unmapped address
    rd_chk(cmd_pkg::OFS_GUARD, 32'h3e8);
    rd_chk(cmd_pkg::OFS_SYMBOL, 32'h2b);
    rd_chk(cmd_pkg::OFS_IDLE_TO, 32'h64);
    rd_chk(cmd_pkg::OFS_JOIN, 32'h0);
    wr_reg(cmd_pkg::OFS_FW_VER, 32'hffff);
    rd_chk(cmd_pkg::OFS_FW_VER, {16'h0, FW});
    rd_chk(cmd_pkg::OFS_HW_VER, {16'h0, HW});
    rd_chk(8'h3c, 32'h0);
    for (int i = 0; i < 4; i++) rd_chk(cmd_pkg::OFS_VER_LONG, vt[i]);
    // guard clamps to its range, then the shortest guard
    wr_reg(cmd_pkg::OFS_GUARD, 32'hfff);
    rd_chk(cmd_pkg::OFS_GUARD, 32'hce4);
    wr_reg(cmd_pkg::OFS_GUARD, 32'h1);
    rd_chk(cmd_pkg::OFS_GUARD, 32'h2);
    // symbol without leading silence is data
    ser(8'h61, 1'b1, 0);
    ser(8'h2b, 1'b1, GQ);
    mode_is(1'b0);
    // guarded symbol enters only after trailing silence; quit leaves
    ser(8'h2b, 1'b0, 1);
    mode_is(1'b0);
    repeat (GQ) @(posedge clk);
    mode_is(1'b1);
    rd_chk(cmd_pkg::OFS_STATUS, 32'h1);
    wr_reg(cmd_pkg::OFS_CTRL, 32'h1 << cmd_pkg::CTRL_QUIT);
    mode_is(1'b0);
    // stray character in trailing silence cancels entry
    repeat (GQ) @(posedge clk);
    ser(8'h2b, 1'b0, 1);
    ser(8'h62, 1'b1, GQ);
    mode_is(1'b0);
    // programmed symbol replaces the default
    wr_reg(cmd_pkg::OFS_SYMBOL, 32'h7e);
    // shortest idle timeout only now, so the quit above is not masked by it
    wr_reg(cmd_pkg::OFS_IDLE_TO, 32'h2);
    ser(8'h2b, 1'b1, GQ);
    mode_is(1'b0);
    ser(8'h7e, 1'b0, GQ);
    mode_is(1'b1);
    // command traffic keeps command mode, silence ends it
    repeat (5) begin
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (5) @(posedge clk);
    end
    mode_is(1'b1);
    repeat (30) @(posedge clk);
    mode_is(1'b0);
    // guarded escape from the host model, then quit before the idle timeout
    u_host.escape(GQ, 8'h7e);
    mode_is(1'b1);
    wr_reg(cmd_pkg::OFS_CTRL, 32'h1 << cmd_pkg::CTRL_QUIT);
    mode_is(1'b0);
    // both failure counters: count, ignore nonzero write, clear, saturate
    for (int k = 0; k < 2; k++) begin
      ev <= 2'b01 << k;
      repeat (3) @(posedge clk);
      ev <= 2'b00;
      @(posedge clk);
      rd_chk(k ? cmd_pkg::OFS_NOREPLY : cmd_pkg::OFS_BUSYFAIL, 32'h3);
      wr_reg(k ? cmd_pkg::OFS_NOREPLY : cmd_pkg::OFS_BUSYFAIL, 32'h5);
      rd_chk(k ? cmd_pkg::OFS_NOREPLY : cmd_pkg::OFS_BUSYFAIL, 32'h3);
      wr_reg(k ? cmd_pkg::OFS_NOREPLY : cmd_pkg::OFS_BUSYFAIL, 32'h0);
      rd_chk(k ? cmd_pkg::OFS_NOREPLY : cmd_pkg::OFS_BUSYFAIL, 32'h0);
    end
    ev <= 2'b11;
    repeat (65540) @(posedge clk);
    ev <= 2'b00;
    rd_chk(cmd_pkg::OFS_BUSYFAIL, 32'hffff);
    rd_chk(cmd_pkg::OFS_NOREPLY, 32'hffff);
    // last good signal level, clamped to its range
    for (int i = 0; i < 2; i++) begin
      good_rx       <= 1'b1;
      good_rx_level <= i ? 7'h70 : 7'h58;
      @(posedge clk);
      good_rx       <= 1'b0;
      @(posedge clk);
      rd_chk(cmd_pkg::OFS_LEVEL, i ? 32'h64 : 32'h58);
    end
    // join options: reserved bits, staged until apply, reinit length
    wr_reg(cmd_pkg::OFS_JOIN, 32'hff);
    rd_chk(cmd_pkg::OFS_JOIN, 32'h0f);
    for (int b = 0; b < 4; b++) begin
      wr_reg(cmd_pkg::OFS_JOIN, 32'h1 << b);
      chk("join_staged", b ? 32'h1 << (b - 1) : 32'h0, {28'h0, join_o});
      wr_reg(cmd_pkg::OFS_CTRL, 32'h1 << cmd_pkg::CTRL_APPLY);
      hold_len(1'b0, 16);
      chk("join", 32'h1 << b, {28'h0, join_o});
    end
    beacon_net <= 1'b1;
    wr_reg(cmd_pkg::OFS_JOIN, 32'h4);
    wr_reg(cmd_pkg::OFS_CTRL, 32'h1 << cmd_pkg::CTRL_APPLY);
    hold_len(1'b0, 16);
    chk("join_beacon", 32'h0, {28'h0, join_o});
    // survey: exponent limit, dwell length, lowest value per channel
    wr_reg(cmd_pkg::OFS_SURV_EXP, 32'h7);
    rd_chk(cmd_pkg::OFS_SURV_EXP, 32'h6);
    wr_reg(cmd_pkg::OFS_SURV_EXP, 32'h1);
    wr_reg(cmd_pkg::OFS_CTRL, 32'h1 << cmd_pkg::CTRL_SURVEY);
    hold_len(1'b1, 16 * 4 * 2);
    for (int i = 0; i < 16; i++) rd_chk(cmd_pkg::OFS_SURV_RES, 32'h50 - i);
    tally_and_finish();
  end
endmodule // command_mode_and_diagnostics_test
`default_nettype wire
